/* File: rtl/pls_pkg.sv */
// constants for the per-port link and slot register bank
`default_nettype none
package pls_pkg;
  // register byte offsets in configuration space
  localparam logic [7:0] PLS_OFS_DEV_ERR_STATUS = 8'h4A;
  localparam logic [7:0] PLS_OFS_LINK_CAP = 8'h4C;
  localparam logic [7:0] PLS_OFS_LINK_CTL = 8'h50;
  localparam logic [7:0] PLS_OFS_LINK_STATUS = 8'h52;
  localparam logic [7:0] PLS_OFS_SLOT_CAP = 8'h54;
  localparam logic [7:0] PLS_OFS_SLOT_CTL = 8'h58;
  localparam logic [7:0] PLS_OFS_SLOT_STATUS = 8'h5A;

  // device error status fields
  localparam int PLS_ERR_COUNT = 4;
  localparam int PLS_ERR_LSB = 0;
  localparam int PLS_AUX_POWER_BIT = 4;
  localparam int PLS_TXN_PENDING_BIT = 5;

  // link capabilities fields
  localparam int PLS_MAX_SPEED_LSB = 0;
  localparam int PLS_MAX_WIDTH_LSB = 4;
  localparam int PLS_PM_SUPPORT_LSB = 10;
  localparam int PLS_L0S_LAT_LSB = 12;
  localparam int PLS_L1_LAT_LSB = 15;
  localparam int PLS_PORT_INDEX_LSB = 24;
  localparam logic [3:0] PLS_SPEED_2G5 = 4'h1;
  localparam logic [5:0] PLS_WIDTH_X1 = 6'h01;
  localparam logic [5:0] PLS_WIDTH_X2 = 6'h02;
  localparam logic [5:0] PLS_WIDTH_X4 = 6'h04;
  localparam logic [5:0] PLS_MAX_WIDTH_RESET = 6'h04;
  localparam logic [1:0] PLS_PM_SUPPORT_L0S_L1 = 2'h3;
  localparam logic [2:0] PLS_L0S_LAT_SEPARATE = 3'h5;
  localparam logic [2:0] PLS_L0S_LAT_COMMON = 3'h3;
  localparam logic [2:0] PLS_L1_LAT_RESET = 3'h2;

  // link control fields
  localparam int PLS_PM_CTL_LSB = 0;
  localparam int PLS_COMPL_BOUNDARY_BIT = 3;
  localparam int PLS_LINK_OFF_BIT = 4;
  localparam int PLS_RETRAIN_BIT = 5;
  localparam int PLS_COMMON_CLK_BIT = 6;
  localparam int PLS_EXT_SYNC_BIT = 7;
  localparam logic [1:0] PLS_PM_CTL_RESET = 2'h0;

  // link status fields
  localparam int PLS_SPEED_NOW_LSB = 0;
  localparam int PLS_NEG_WIDTH_LSB = 4;
  localparam int PLS_TRAIN_ERR_BIT = 10;
  localparam int PLS_TRAIN_ACTIVE_BIT = 11;
  localparam int PLS_SLOT_CLK_BIT = 12;

  // slot capabilities fields
  localparam int PLS_POWER_VALUE_LSB = 7;
  localparam int PLS_POWER_SCALE_LSB = 15;
  localparam int PLS_SLOT_INDEX_LSB = 19;

  // slot control and status constants, hot-plug absent
  localparam int PLS_ATTN_IND_LSB = 6;
  localparam int PLS_POWER_IND_LSB = 8;
  localparam logic [1:0] PLS_ATTN_IND_OFF = 2'h3;
  localparam logic [1:0] PLS_POWER_IND_ON = 2'h1;
  localparam int PLS_PRESENCE_BIT = 6;

  // fast training sequence counts sent on L0s exit
  localparam logic [12:0] PLS_FTS_EXTENDED = 13'h1000;

  // port encodings
  localparam logic [1:0] PLS_PORT_UPSTREAM = 2'h0;
endpackage : pls_pkg
`default_nettype wire

/* File: rtl/pls_port_link_slot_regs.sv */
// link, slot and device error status register bank for one switch port
//
// What this block does
// - error seen bits set always, write one clears
// - aux power and pending bits read zero
// - max and current speed read 2.5G code
// - max width resets x4; bad codes train x1
// - power management support reads L0s plus L1
// - L0s exit latency follows common clock setting
// - L1 exit latency defaults to code two
// - port index reads this port's number
// - pm control resets disabled, eeprom may load
// - link off on downstream; upstream stays zero
// - retrain write pulses recovery, reads zero
// - upstream retrain needs register unlock set
// - common clock configuration bit is writable
// - extended sync sends 4096 fts sets
// - status shows width, training error, training
// - slot clock from strap, eeprom may override
// - power limit message on write or up
// - power scale code selects value multiplier
// - slot power fields zero without slot
// - hot-plug bits constant, indicators fixed codes
// - read completion boundary is constant zero
// - slot implemented input gates power fields
//
// Implementation choice: the strobed register port.
`default_nettype none
module pls_port_link_slot_regs
  import pls_pkg::*;
#(
  parameter logic [1:0] PORT_ID = 2'h0,
  parameter logic [12:0] FTS_NORMAL = 13'h0040
) (
  input wire logic clock,
  input wire logic rstn,
  // register port
  input wire logic [7:0] address,
  input wire logic [31:0] writeData,
  input wire logic writeStrobe,
  input wire logic readStrobe,
  output logic [31:0] readData,
  // configuration context
  input wire logic slotImplemented,
  input wire logic registerUnlock,
  input wire logic upstreamCommonClockStrap,
  input wire logic downstreamCommonClockStrap,
  // serial eeprom load
  input wire logic eepromLoad,
  input wire logic [1:0] eepromPmControl,
  input wire logic eepromSlotClock,
  // error events, one-cycle pulses: correctable, nonfatal, fatal, unsupported
  input wire logic [3:0] errorEvent,
  // link layer status
  input wire logic linkDlUp,
  input wire logic [5:0] linkWidthNow,
  input wire logic linkTrainingError,
  input wire logic linkTrainingActive,
  // link layer controls
  output logic linkRetrainGo,
  output logic linkOff,
  output logic extendedSyncOn,
  output logic [12:0] ftsSetCount,
  output logic [1:0] activePmControl,
  output logic commonClockCfg,
  output logic [5:0] trainWidth,
  // set slot power limit message request
  output logic powerLimitSend,
  output logic [7:0] powerLimitValue,
  output logic [1:0] powerLimitScale
);

  localparam logic IS_UPSTREAM = (PORT_ID == PLS_PORT_UPSTREAM);

  logic [3:0] errSeen;
  logic [5:0] maxWidth;
  logic [2:0] l1Latency;
  logic slotClock;
  logic strapTaken;
  logic [7:0] slotPowerValue;
  logic [1:0] slotPowerScale;
  logic [12:0] slotIndex;
  logic dlUpLast;
  logic [2:0] l0sLatency;
  logic [7:0] powerValueSeen;
  logic [1:0] powerScaleSeen;
  logic [12:0] slotIndexSeen;
  logic [15:0] errStatusWord;
  logic [31:0] linkCapWord;
  logic [15:0] linkCtlWord;
  logic [15:0] linkStatusWord;
  logic [31:0] slotCapWord;
  logic [15:0] slotCtlWord;
  logic [15:0] slotStatusWord;
  logic [31:0] next_readData;
  logic writeErrStatus;
  logic writeLinkCap;
  logic writeLinkCtl;
  logic writeSlotCap;
  logic retrainAllowed;

  // write decode, one strobe per writable register
  assign writeErrStatus = writeStrobe && (address == PLS_OFS_DEV_ERR_STATUS);
  assign writeLinkCap = writeStrobe && (address == PLS_OFS_LINK_CAP);
  assign writeLinkCtl = writeStrobe && (address == PLS_OFS_LINK_CTL);
  assign writeSlotCap = writeStrobe && (address == PLS_OFS_SLOT_CAP);

  // error seen flags: an event in the clearing cycle survives the clear
  genvar e;
  generate
    for (e = 0; e < PLS_ERR_COUNT; e++) begin : gErr
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          errSeen[e] <= 1'b0;
        end else if (errorEvent[e]) begin
          errSeen[e] <= 1'b1;
        end else if (writeErrStatus && writeData[PLS_ERR_LSB + e]) begin
          errSeen[e] <= 1'b0;
        end
      end
    end
  endgenerate

  // link capability writable fields
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      maxWidth <= PLS_MAX_WIDTH_RESET;
      l1Latency <= PLS_L1_LAT_RESET;
    end else if (writeLinkCap) begin
      maxWidth <= writeData[PLS_MAX_WIDTH_LSB +: 6];
      l1Latency <= writeData[PLS_L1_LAT_LSB +: 3];
    end
  end

  // width handed to training; reserved codes fall back to x1
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      trainWidth <= PLS_MAX_WIDTH_RESET;
    end else begin
      case (maxWidth)
        PLS_WIDTH_X1, PLS_WIDTH_X2, PLS_WIDTH_X4: begin
          trainWidth <= maxWidth;
        end
        default: begin
          trainWidth <= PLS_WIDTH_X1;
        end
      endcase
    end
  end

  // link control register; eeprom load runs after reset like a write
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      activePmControl <= PLS_PM_CTL_RESET;
      linkOff <= 1'b0;
      commonClockCfg <= 1'b0;
      extendedSyncOn <= 1'b0;
    end else if (writeLinkCtl) begin
      activePmControl <= writeData[PLS_PM_CTL_LSB +: 2];
      linkOff <= writeData[PLS_LINK_OFF_BIT] && !IS_UPSTREAM;
      commonClockCfg <= writeData[PLS_COMMON_CLK_BIT];
      extendedSyncOn <= writeData[PLS_EXT_SYNC_BIT];
    end else if (eepromLoad) begin
      activePmControl <= eepromPmControl;
    end
  end

  // retrain is a pulse, never stored, so it always reads back zero
  assign retrainAllowed = !IS_UPSTREAM || registerUnlock;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      linkRetrainGo <= 1'b0;
    end else begin
      linkRetrainGo <= writeLinkCtl && writeData[PLS_RETRAIN_BIT] && retrainAllowed;
    end
  end

  // fts count for the transmitter on each L0s exit
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ftsSetCount <= FTS_NORMAL;
    end else begin
      ftsSetCount <= extendedSyncOn ? PLS_FTS_EXTENDED : FTS_NORMAL;
    end
  end

  // slot clock: strap caught on the first edge after reset release,
  // since an async reset may only load constants
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      strapTaken <= 1'b0;
      slotClock <= 1'b0;
    end else if (!strapTaken) begin
      strapTaken <= 1'b1;
      slotClock <= IS_UPSTREAM ? upstreamCommonClockStrap : downstreamCommonClockStrap;
    end else if (eepromLoad) begin
      slotClock <= eepromSlotClock;
    end
  end

  // slot power fields only take writes while a slot is present
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      slotPowerValue <= 8'h00;
      slotPowerScale <= 2'h0;
      slotIndex <= 13'h0000;
    end else if (writeSlotCap && slotImplemented) begin
      slotPowerValue <= writeData[PLS_POWER_VALUE_LSB +: 8];
      slotPowerScale <= writeData[PLS_POWER_SCALE_LSB +: 2];
      slotIndex <= writeData[PLS_SLOT_INDEX_LSB +: 13];
    end
  end

  // visible slot fields read zero while no slot is implemented
  assign powerValueSeen = slotImplemented ? slotPowerValue : 8'h00;
  assign powerScaleSeen = slotImplemented ? slotPowerScale : 2'h0;
  assign slotIndexSeen = slotImplemented ? slotIndex : 13'h0000;

  // power limit message: one request per slot cap write or DL_Up rise.
  // the payload is taken from the write data itself when a write with a slot present causes it,
  // so the message never carries the value from before the write
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dlUpLast <= 1'b0;
      powerLimitSend <= 1'b0;
      powerLimitValue <= 8'h00;
      powerLimitScale <= 2'h0;
    end else begin
      dlUpLast <= linkDlUp;
      powerLimitSend <= writeSlotCap || (linkDlUp && !dlUpLast);
      if (writeSlotCap && slotImplemented) begin
        powerLimitValue <= writeData[PLS_POWER_VALUE_LSB +: 8];
        powerLimitScale <= writeData[PLS_POWER_SCALE_LSB +: 2];
      end else begin
        powerLimitValue <= powerValueSeen;
        powerLimitScale <= powerScaleSeen;
      end
    end
  end

  // L0s exit is faster when both ends share one reference clock
  assign l0sLatency = commonClockCfg ? PLS_L0S_LAT_COMMON : PLS_L0S_LAT_SEPARATE;

  // device error status image; fixed bits stay zero
  always_comb begin
    errStatusWord = 16'h0000;
    errStatusWord[PLS_ERR_LSB +: PLS_ERR_COUNT] = errSeen;
    errStatusWord[PLS_AUX_POWER_BIT] = 1'b0;
    errStatusWord[PLS_TXN_PENDING_BIT] = 1'b0;
  end

  // link capabilities image
  always_comb begin
    linkCapWord = 32'h0000_0000;
    linkCapWord[PLS_MAX_SPEED_LSB +: 4] = PLS_SPEED_2G5;
    linkCapWord[PLS_MAX_WIDTH_LSB +: 6] = maxWidth;
    linkCapWord[PLS_PM_SUPPORT_LSB +: 2] = PLS_PM_SUPPORT_L0S_L1;
    linkCapWord[PLS_L0S_LAT_LSB +: 3] = l0sLatency;
    linkCapWord[PLS_L1_LAT_LSB +: 3] = l1Latency;
    linkCapWord[PLS_PORT_INDEX_LSB +: 8] = {6'h00, PORT_ID};
  end

  // link control image; retrain and completion boundary read zero
  always_comb begin
    linkCtlWord = 16'h0000;
    linkCtlWord[PLS_PM_CTL_LSB +: 2] = activePmControl;
    linkCtlWord[PLS_COMPL_BOUNDARY_BIT] = 1'b0;
    linkCtlWord[PLS_LINK_OFF_BIT] = linkOff;
    linkCtlWord[PLS_RETRAIN_BIT] = 1'b0;
    linkCtlWord[PLS_COMMON_CLK_BIT] = commonClockCfg;
    linkCtlWord[PLS_EXT_SYNC_BIT] = extendedSyncOn;
  end

  // link status image, live from the link layer
  always_comb begin
    linkStatusWord = 16'h0000;
    linkStatusWord[PLS_SPEED_NOW_LSB +: 4] = PLS_SPEED_2G5;
    linkStatusWord[PLS_NEG_WIDTH_LSB +: 6] = linkWidthNow;
    linkStatusWord[PLS_TRAIN_ERR_BIT] = linkTrainingError;
    linkStatusWord[PLS_TRAIN_ACTIVE_BIT] = linkTrainingActive;
    linkStatusWord[PLS_SLOT_CLK_BIT] = slotClock;
  end

  // slot images; every hot-plug bit is a constant
  always_comb begin
    slotCapWord = 32'h0000_0000;
    slotCapWord[PLS_POWER_VALUE_LSB +: 8] = powerValueSeen;
    slotCapWord[PLS_POWER_SCALE_LSB +: 2] = powerScaleSeen;
    slotCapWord[PLS_SLOT_INDEX_LSB +: 13] = slotIndexSeen;
    slotCtlWord = 16'h0000;
    slotCtlWord[PLS_ATTN_IND_LSB +: 2] = PLS_ATTN_IND_OFF;
    slotCtlWord[PLS_POWER_IND_LSB +: 2] = PLS_POWER_IND_ON;
    slotStatusWord = 16'h0000;
    slotStatusWord[PLS_PRESENCE_BIT] = 1'b1;
  end

  // read mux; unmapped addresses answer zero
  always_comb begin
    next_readData = 32'h0000_0000;
    if (readStrobe) begin
      case (address)
        PLS_OFS_DEV_ERR_STATUS: next_readData = {16'h0000, errStatusWord};
        PLS_OFS_LINK_CAP: next_readData = linkCapWord;
        PLS_OFS_LINK_CTL: next_readData = {16'h0000, linkCtlWord};
        PLS_OFS_LINK_STATUS: next_readData = {16'h0000, linkStatusWord};
        PLS_OFS_SLOT_CAP: next_readData = slotCapWord;
        PLS_OFS_SLOT_CTL: next_readData = {16'h0000, slotCtlWord};
        PLS_OFS_SLOT_STATUS: next_readData = {16'h0000, slotStatusWord};
        default: next_readData = 32'h0000_0000;
      endcase
    end
  end

  // read data stands for exactly the cycle after the strobe
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      readData <= 32'h0000_0000;
    end else begin
      readData <= next_readData;
    end
  end

endmodule : pls_port_link_slot_regs
`default_nettype wire

/* File: tb/pls_regs_asserts.sv */
// port-level assertions for the link and slot register bank
`default_nettype none
module pls_regs_asserts
  import pls_pkg::*;
#(
  parameter logic [1:0] PORT_ID = 2'h0,
  parameter logic [12:0] FTS_NORMAL = 13'h0040
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [7:0] address,
  input wire logic [31:0] writeData,
  input wire logic writeStrobe,
  input wire logic readStrobe,
  input wire logic [31:0] readData,
  input wire logic slotImplemented,
  input wire logic registerUnlock,
  input wire logic linkRetrainGo,
  input wire logic linkOff,
  input wire logic extendedSyncOn,
  input wire logic [12:0] ftsSetCount,
  input wire logic [1:0] activePmControl,
  input wire logic commonClockCfg,
  input wire logic [5:0] trainWidth,
  input wire logic powerLimitSend,
  input wire logic [7:0] powerLimitValue,
  input wire logic [1:0] powerLimitScale
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  logic ctlWr;
  logic capWr;
  // write decodes seen at the pins
  assign ctlWr = writeStrobe && address == PLS_OFS_LINK_CTL;
  assign capWr = writeStrobe && address == PLS_OFS_SLOT_CAP;

  a_read_window: assert property (!$past(readStrobe) |-> readData == 32'h0)
    else $error("read data seen outside its cycle");
  a_retrain_cause: assert property (linkRetrainGo |-> $past(ctlWr) && $past(writeData[5]))
    else $error("retrain pulse without a retrain write");
  a_retrain_once: assert property (linkRetrainGo |=> !linkRetrainGo)
    else $error("retrain pulse longer than one cycle");
  a_unlock_retrain: assert property (ctlWr && writeData[5] && (PORT_ID != 2'h0 || registerUnlock) |=> linkRetrainGo)
    else $error("qualified retrain write gave no pulse");
  a_locked_upstream: assert property (PORT_ID == 2'h0 && linkRetrainGo |-> $past(registerUnlock))
    else $error("upstream retrain while locked");
  a_link_off_up: assert property (PORT_ID == 2'h0 |-> !linkOff)
    else $error("link off set on upstream port");
  a_ctl_apply: assert property (ctlWr |=> activePmControl == $past(writeData[1:0]) &&
    commonClockCfg == $past(writeData[6]) && extendedSyncOn == $past(writeData[7]))
    else $error("link control outputs do not follow write");
  a_fts_count: assert property (ftsSetCount == ($past(extendedSyncOn) ? 13'h1000 : FTS_NORMAL))
    else $error("fts count does not follow extended sync");
  a_width_legal: assert property (trainWidth inside {6'h01, 6'h02, 6'h04})
    else $error("training width outside legal codes");
  a_power_write: assert property (capWr |=> powerLimitSend)
    else $error("slot capability write sent no message");
  a_power_noslot: assert property (powerLimitSend && !$past(slotImplemented) |->
    powerLimitValue == 8'h00 && powerLimitScale == 2'h0)
    else $error("power payload nonzero without slot");
  c_retrain: cover property (linkRetrainGo);
  c_power_slot: cover property (powerLimitSend && slotImplemented);
  c_ext_sync: cover property (extendedSyncOn ##1 ftsSetCount == 13'h1000);
endmodule : pls_regs_asserts
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the link and slot register bank
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module tb_top
  import pls_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [12:0] FTS = 13'h0040;
  logic clock = 1'b0, rstn = 1'b0, writeStrobe = 1'b0, readStrobe = 1'b0, slotImplemented = 1'b0;
  logic registerUnlock = 1'b0, eepromLoad = 1'b0, eepromSlotClock = 1'b0, linkDlUp = 1'b0;
  logic linkTrainingError = 1'b0, linkTrainingActive = 1'b0;
  logic [7:0] address = 8'h00;
  logic [31:0] writeData = 32'h0;
  logic [1:0] eepromPmControl = 2'h0;
  logic [3:0] errorEvent = 4'h0;
  logic [5:0] linkWidthNow = 6'h04;
  logic [31:0] readData;
  logic linkRetrainGo, linkOff, extendedSyncOn, commonClockCfg, powerLimitSend;
  logic [12:0] ftsSetCount;
  logic [1:0] activePmControl, powerLimitScale;
  logic [5:0] trainWidth;
  logic [7:0] powerLimitValue;
  // bench model state: raw capability bits, controls, error flags, slot fields
  logic [31:0] rnd = 32'hC064, d, capSt = 32'h00010040, slotSt = 32'h0;
  logic [3:0] errSt = 4'h0;
  logic [1:0] pmSt = 2'h0;
  logic common_clock_cfg = 1'b0, extended_sync_on = 1'b0, sclk = 1'b1;
  logic [5:0] wtab [3] = '{6'h01, 6'h02, 6'h04};
  int n_errors = 0, checked = 0, k;

  pls_port_link_slot_regs #(.PORT_ID(2'h0), .FTS_NORMAL(FTS)) i_dut (.clock, .rstn, .address, .writeData,
    .writeStrobe, .readStrobe, .readData, .slotImplemented, .registerUnlock, .upstreamCommonClockStrap(1'b1),
    .downstreamCommonClockStrap(1'b0), .eepromLoad, .eepromPmControl, .eepromSlotClock, .errorEvent, .linkDlUp,
    .linkWidthNow, .linkTrainingError, .linkTrainingActive, .linkRetrainGo, .linkOff, .extendedSyncOn,
    .ftsSetCount, .activePmControl, .commonClockCfg, .trainWidth, .powerLimitSend, .powerLimitValue,
    .powerLimitScale);
  logic [31:0] dsReadData;
  logic dsRetrain, dsLinkOff;
  // a downstream copy on the same inputs covers the port-dependent rules
  pls_port_link_slot_regs #(.PORT_ID(2'h1), .FTS_NORMAL(FTS)) i_dut_ds (.clock, .rstn, .address, .writeData,
    .writeStrobe, .readStrobe, .readData(dsReadData), .slotImplemented, .registerUnlock,
    .upstreamCommonClockStrap(1'b1), .downstreamCommonClockStrap(1'b0), .eepromLoad, .eepromPmControl,
    .eepromSlotClock, .errorEvent, .linkDlUp, .linkWidthNow, .linkTrainingError, .linkTrainingActive,
    .linkRetrainGo(dsRetrain), .linkOff(dsLinkOff), .extendedSyncOn(), .ftsSetCount(), .activePmControl(),
    .commonClockCfg(), .trainWidth(), .powerLimitSend(), .powerLimitValue(), .powerLimitScale());

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // expected register images; latency code depends on the common clock bit
  function automatic logic [31:0] expCap();
    return {8'h00, 6'h00, capSt[17:15], common_clock_cfg ? 3'h3 : 3'h5, 2'h3, capSt[9:4], 4'h1};
  endfunction : expCap
  function automatic logic [31:0] expStatus();
    return {19'h0, sclk, linkTrainingActive, linkTrainingError, linkWidthNow, 4'h1};
  endfunction : expStatus
  function automatic logic [31:0] expCtl();
    return {24'h0, extended_sync_on, common_clock_cfg, 4'h0, pmSt};
  endfunction : expCtl

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    writeStrobe <= 1'b1;
    address <= a;
    writeData <= v;
    @(posedge clock);
    writeStrobe <= 1'b0;
    #1;
  endtask : wr
  // read data is only valid in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    readStrobe <= 1'b1;
    address <= a;
    @(posedge clock);
    readStrobe <= 1'b0;
    #1;
    `CHK("read data", e, readData)
  endtask : rd
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    forever #25 clock = ~clock;
  end
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (3000) @(posedge clock);
    n_errors++;
    end_of_test();
  end

  initial begin
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    #1;
    `CHK("train width", 6'h04, trainWidth)
    `CHK("fts count", FTS, ftsSetCount)
    rd(PLS_OFS_DEV_ERR_STATUS, 32'h0);
    rd(PLS_OFS_LINK_CAP, expCap());
    rd(PLS_OFS_LINK_CTL, 32'h0);
    rd(PLS_OFS_LINK_STATUS, expStatus());
    `CHK("ds link status", expStatus() & 32'hFFFFEFFF, dsReadData)
    rd(PLS_OFS_SLOT_CAP, 32'h0);
    rd(8'h60, 32'h0);
    wr(PLS_OFS_SLOT_CTL, 32'hFFFF);
    wr(PLS_OFS_SLOT_STATUS, 32'hFFFF);
    rd(PLS_OFS_SLOT_CTL, 32'h01C0);
    rd(PLS_OFS_SLOT_STATUS, 32'h0040);
    $display("reset values test done");
    // error flags: random events, then partial write-one clears
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      errorEvent <= rnd[3:0];
      @(posedge clock);
      errorEvent <= 4'h0;
      errSt = errSt | rnd[3:0];
      rd(PLS_OFS_DEV_ERR_STATUS, {28'h0, errSt});
      wr(PLS_OFS_DEV_ERR_STATUS, {rnd[31:6], 2'h3, rnd[7:4]});
      errSt = errSt & ~rnd[7:4];
      wr(PLS_OFS_DEV_ERR_STATUS, {rnd[31:4], errSt & ~rnd[7:4]} & 32'hFFFFFFF0);
      rd(PLS_OFS_DEV_ERR_STATUS, {28'h0, errSt});
    end
    // an event in the very cycle of its clear must survive
    @(posedge clock);
    errorEvent <= 4'hF;
    writeStrobe <= 1'b1;
    address <= PLS_OFS_DEV_ERR_STATUS;
    writeData <= 32'h0000_000F;
    @(posedge clock);
    errorEvent <= 4'h0;
    writeStrobe <= 1'b0;
    errSt = 4'hF;
    rd(PLS_OFS_DEV_ERR_STATUS, {28'h0, errSt});
    $display("error status test done");
    // link control: all unlock and retrain combinations first
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      d = rnd;
      d[5] = (i < 4) ? ~i[1] : rnd[5];
      registerUnlock <= i[0];
      wr(PLS_OFS_LINK_CTL, d);
      pmSt = d[1:0];
      common_clock_cfg = d[6];
      extended_sync_on = d[7];
      `CHK("retrain", d[5] & i[0], linkRetrainGo)
      `CHK("ds retrain", d[5], dsRetrain)
      `CHK("ds link off", d[4], dsLinkOff)
      `CHK("link off", 1'b0, linkOff)
      `CHK("pm control", pmSt, activePmControl)
      `CHK("common clock", common_clock_cfg, commonClockCfg)
      `CHK("ext sync", extended_sync_on, extendedSyncOn)
      rd(PLS_OFS_LINK_CTL, expCtl());
      `CHK("ds link ctl", expCtl() | {27'h0, d[4], 4'h0}, dsReadData)
      `CHK("fts count", extended_sync_on ? 13'h1000 : FTS, ftsSetCount)
      rd(PLS_OFS_LINK_CAP, expCap());
      `CHK("ds link cap", expCap() | 32'h0100_0000, dsReadData)
    end
    $display("link control test done");
    // width codes: legal ones, then random codes, legal or not
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      d = rnd;
      d[9:4] = (i < 3) ? wtab[i] : rnd[9:4];
      wr(PLS_OFS_LINK_CAP, d);
      capSt = d;
      rd(PLS_OFS_LINK_CAP, expCap());
      `CHK("train width", (d[9:4] inside {6'h01, 6'h02, 6'h04}) ? d[9:4] : 6'h01, trainWidth)
    end
    $display("link width test done");
    // link status inputs and eeprom loading
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      linkWidthNow <= rnd[5:0];
      linkTrainingError <= rnd[6];
      linkTrainingActive <= rnd[7];
      eepromPmControl <= rnd[9:8];
      eepromSlotClock <= rnd[10];
      eepromLoad <= 1'b1;
      @(posedge clock);
      eepromLoad <= 1'b0;
      pmSt = rnd[9:8];
      sclk = rnd[10];
      rd(PLS_OFS_LINK_STATUS, expStatus());
      rd(PLS_OFS_LINK_CTL, expCtl());
    end
    $display("link status test done");
    // slot power: every scale code with a slot, writes refused without
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      d = rnd & 32'hFFFDFFFF;
      d[16:15] = i[2:1];
      slotImplemented <= i[0];
      wr(PLS_OFS_SLOT_CAP, d);
      if (i[0]) slotSt = d & 32'hFFF9FF80;
      `CHK("limit send", 1'b1, powerLimitSend)
      `CHK("limit value", i[0] ? d[14:7] : 8'h00, powerLimitValue)
      `CHK("limit scale", i[0] ? d[16:15] : 2'h0, powerLimitScale)
      rd(PLS_OFS_SLOT_CAP, i[0] ? slotSt : 32'h0);
    end
    linkDlUp <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      #1;
      k++;
    end while (powerLimitSend !== 1'b1 && k < 4);
    `CHK("link up send", 1'b1, powerLimitSend)
    `CHK("link up value", slotSt[14:7], powerLimitValue)
    $display("slot power test done");
    end_of_test();
  end
endmodule : tb_top

bind pls_port_link_slot_regs pls_regs_asserts #(.PORT_ID(PORT_ID), .FTS_NORMAL(FTS_NORMAL)) i_chk (.clock,
  .rstn, .address, .writeData, .writeStrobe, .readStrobe, .readData, .slotImplemented, .registerUnlock,
  .linkRetrainGo, .linkOff, .extendedSyncOn, .ftsSetCount, .activePmControl, .commonClockCfg, .trainWidth,
  .powerLimitSend, .powerLimitValue, .powerLimitScale);
`default_nettype wire
